// ==== fwec_ctrl.v ====
// Flash write and erase controller with AHB-Lite register slave
//
// Notes on behaviour
// - Busy bit high during any write or erase
// - Single-write-busy high while one byte programs
// - Read enable on demand, or always if set
// - Write bit starts page write at address
// - Erase plus write: erase first, then write
// - Erase bit alone erases addressed page
// - Data bytes programmed at address; reset zero
// - Address high bits 5:1 page, 0 row MSB
// - Low bits 7:6 row, 5:0 byte location
// - Address high six bits, reset zero
// - Six-bit timing field, resets 0x25
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fwec_map.vh"
module fwec_ctrl #(
  parameter TW = 16
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RST,
  // AHB-Lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // Flash array side
  input wire FLASH_READ_REQ,
  output reg FLASH_RD_EN,
  output reg FLASH_ERASE_EN,
  output reg FLASH_PROG_EN,
  output reg [4:0] FLASH_PAGE,
  output reg [2:0] FLASH_ROW,
  output reg [5:0] FLASH_COL,
  output reg [7:0] FLASH_WDATA
);

  localparam S_IDLE = 2'h0;
  localparam S_ERASE = 2'h1;
  localparam S_WAITD = 2'h2;
  localparam S_PROG = 2'h3;

  reg [5:0] write_timing_r;
  reg [7:0] address_low_r;
  reg [5:0] address_high_r;
  reg continuous_read_r;
  reg spare5_r;
  reg [7:0] write_data_r;
  reg data_pend_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg wr_pend_r;
  reg [7:0] dph_addr_r;
  reg dph_wr_r;
  reg tmr_load;
  reg [TW-1:0] tmr_count;
  reg [31:0] rdata_nxt;

  wire tmr_done;
  wire busy;
  wire swbusy;
  wire ap_valid;
  wire wr_ctl;
  wire wr_data;
  wire [7:0] wbyte;
  wire [TW-1:0] t_ext;
  wire [TW-1:0] erase_cnt;
  wire [TW-1:0] prog_cnt;
  wire sel_timing;
  wire sel_addr_low;
  wire sel_addr_high;
  wire sel_control;
  wire sel_data;
  wire start_erase;
  wire start_write;
  wire byte_done;
  wire page_end;
  wire [7:0] ctl_rd_byte;

  // Pulse timer shared by erase and program
  fwec_pulse_timer #(.W(TW)) u_timer (
    .clk(REF_CLK),
    .rst(RST),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // Status derived from sequencer state
  assign busy = (state_r != S_IDLE);
  assign swbusy = (state_r == S_PROG);

  // Bus phase decode
  assign ap_valid = HSEL & HREADY & HTRANS[1];
  assign wbyte = HWDATA[7:0];
  assign wr_ctl = dph_wr_r & sel_control;
  assign wr_data = dph_wr_r & sel_data;

  // Register select from the captured word index
  assign sel_timing = (dph_addr_r == `FWEC_IDX_WRITE_TIMING);
  assign sel_addr_low = (dph_addr_r == `FWEC_IDX_ADDRESS_LOW);
  assign sel_addr_high = (dph_addr_r == `FWEC_IDX_ADDRESS_HIGH);
  assign sel_control = (dph_addr_r == `FWEC_IDX_OPERATION_CONTROL);
  assign sel_data = (dph_addr_r == `FWEC_IDX_WRITE_DATA);

  // Start requests carried by a control write
  assign start_erase = wr_ctl & wbyte[`FWEC_CTL_ERASE];
  assign start_write = wr_ctl & wbyte[`FWEC_CTL_WRITE];

  // Byte finished, and last byte location of the row
  assign byte_done = (state_r == S_PROG) & tmr_done;
  assign page_end = (address_low_r[5:0] == 6'h3F);

  // Control readback; trigger bits always read zero
  assign ctl_rd_byte = {busy, swbusy, spare5_r,
                        continuous_read_r, 4'h0};

  // Pulse lengths scale with the timing value
  assign t_ext = {{(TW-6){1'b0}}, write_timing_r};
  assign erase_cnt = t_ext * `FWEC_ERASE_UNITS;
  assign prog_cnt = t_ext * `FWEC_PROG_UNITS;

  // Address phase capture; word index from byte address
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dph_addr_r <= 8'h00;
      dph_wr_r <= 1'b0;
    end else begin
      dph_addr_r <= HADDR[9:2];
      dph_wr_r <= ap_valid & HWRITE;
    end
  end

  // Zero-wait OKAY slave
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Timing register; upper two bits not kept
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      write_timing_r <= `FWEC_RST_WRITE_TIMING;
    end else if (dph_wr_r && sel_timing) begin
      write_timing_r <= wbyte[5:0];
    end
  end

  // Address low; software write wins over the advance
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      address_low_r <= `FWEC_RST_ADDRESS;
    end else if (dph_wr_r && sel_addr_low) begin
      address_low_r <= wbyte;
    end else if (byte_done) begin
      address_low_r <= address_low_r + 8'h01;
    end
  end

  // Address high; six bits kept
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      address_high_r <= 6'h00;
    end else if (dph_wr_r && sel_addr_high) begin
      address_high_r <= wbyte[5:0];
    end
  end

  // Continuous read enable bit
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      continuous_read_r <= 1'b0;
    end else if (wr_ctl) begin
      continuous_read_r <= wbyte[`FWEC_CTL_CONT_READ];
    end
  end

  // Spare control bit, plain storage
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      spare5_r <= 1'b0;
    end else if (wr_ctl) begin
      spare5_r <= wbyte[`FWEC_CTL_SPARE5];
    end
  end

  // Write data byte
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      write_data_r <= `FWEC_RST_WRITE_DATA;
    end else if (wr_data) begin
      write_data_r <= wbyte;
    end
  end

  // Data pending: a new byte wins over the consume
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      data_pend_r <= 1'b0;
    end else if (wr_data) begin
      data_pend_r <= 1'b1;
    end else if (state_r == S_WAITD && data_pend_r) begin
      data_pend_r <= 1'b0;
    end
  end

  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_count = prog_cnt;
    case (state_r)
      S_IDLE: begin
        // Starts only accepted while idle
        if (start_erase) begin
          state_nxt = S_ERASE;
          tmr_load = 1'b1;
          tmr_count = erase_cnt;
        end else if (start_write) begin
          state_nxt = S_WAITD;
        end
      end
      S_ERASE: begin
        if (tmr_done) begin
          state_nxt = wr_pend_r ? S_WAITD : S_IDLE;
        end
      end
      S_WAITD: begin
        if (data_pend_r) begin
          state_nxt = S_PROG;
          tmr_load = 1'b1;
        end
      end
      S_PROG: begin
        if (tmr_done) begin
          // Page done when byte location wraps
          if (page_end) begin
            state_nxt = S_IDLE;
          end else begin
            state_nxt = S_WAITD;
          end
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Sequencer state
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Write owed after the erase; ignored while busy
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
    end else if (state_r == S_IDLE && wr_ctl) begin
      wr_pend_r <= start_write;
    end
  end

  // Read enable, on demand or continuous
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FLASH_RD_EN <= 1'b0;
    end else begin
      FLASH_RD_EN <= continuous_read_r | FLASH_READ_REQ;
    end
  end

  // Erase and program strobes
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FLASH_ERASE_EN <= 1'b0;
      FLASH_PROG_EN <= 1'b0;
    end else begin
      FLASH_ERASE_EN <= (state_nxt == S_ERASE);
      FLASH_PROG_EN <= (state_nxt == S_PROG);
    end
  end

  // Page select
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FLASH_PAGE <= 5'h00;
    end else begin
      FLASH_PAGE <= address_high_r[5:1];
    end
  end

  // Row and byte location
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FLASH_ROW <= 3'h0;
      FLASH_COL <= 6'h00;
    end else begin
      FLASH_ROW <= {address_high_r[0], address_low_r[7:6]};
      FLASH_COL <= address_low_r[5:0];
    end
  end

  // Byte presented to the array
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FLASH_WDATA <= 8'h00;
    end else begin
      FLASH_WDATA <= write_data_r;
    end
  end

  // Read mux; unmapped words read zero
  always @* begin
    rdata_nxt = 32'h00000000;
    case (HADDR[9:2])
      `FWEC_IDX_WRITE_TIMING: rdata_nxt = {26'h0000000, write_timing_r};
      `FWEC_IDX_ADDRESS_LOW: rdata_nxt = {24'h000000, address_low_r};
      `FWEC_IDX_ADDRESS_HIGH: rdata_nxt = {26'h0000000, address_high_r};
      `FWEC_IDX_OPERATION_CONTROL: rdata_nxt = {24'h000000, ctl_rd_byte};
      `FWEC_IDX_WRITE_DATA: rdata_nxt = {24'h000000, write_data_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data captured in the address phase
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      HRDATA <= 32'h00000000;
    end else if (ap_valid & ~HWRITE) begin
      HRDATA <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== fwec_map.vh ====
// Register offsets, field positions, reset values and timing for the flash controller
`ifndef FWEC_MAP_VH
`define FWEC_MAP_VH
// Register indexes (byte address is four times the index)
`define FWEC_IDX_WRITE_TIMING 8'hAB
`define FWEC_IDX_ADDRESS_LOW 8'hAC
`define FWEC_IDX_ADDRESS_HIGH 8'hAD
`define FWEC_IDX_OPERATION_CONTROL 8'hAE
`define FWEC_IDX_WRITE_DATA 8'hAF
// Reset values
`define FWEC_RST_WRITE_TIMING 6'h25
`define FWEC_RST_ADDRESS 8'h00
`define FWEC_RST_WRITE_DATA 8'h00
// Operation control fields
`define FWEC_CTL_BUSY 7
`define FWEC_CTL_SWBUSY 6
`define FWEC_CTL_SPARE5 5
`define FWEC_CTL_CONT_READ 4
`define FWEC_CTL_WRITE 1
`define FWEC_CTL_ERASE 0
// Timing generator: pulse length in units of timing value
`define FWEC_ERASE_UNITS 16'h0040
`define FWEC_PROG_UNITS 16'h0002
`endif

// ==== fwec_pulse_timer.v ====
// Down counter timing one flash program or erase pulse
`timescale 1ns/1ps
`default_nettype none
module fwec_pulse_timer #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire load,
  input wire [W-1:0] count,
  output reg done
);
  reg [W-1:0] cnt_r;
  reg run_r;
  // Load then count down, pulse done at zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_r <= count;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == {W{1'b0}}) begin
          run_r <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== fwec_ctrl_checker.sv ====
// Port assertions for the flash write and erase controller
`timescale 1ns/1ps
`default_nettype none
module fwec_ctrl_checker (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Bus answer
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Flash side
  input wire logic FLASH_READ_REQ,
  input wire logic FLASH_RD_EN,
  input wire logic FLASH_ERASE_EN,
  input wire logic FLASH_PROG_EN,
  input wire logic [7:0] FLASH_WDATA,
  input wire logic [5:0] FLASH_COL
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Bus answer, read enable and pulse shape
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  a_rdata_byte: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_rden_follow: assert property (!$past(RST) && $past(FLASH_READ_REQ)
    |-> FLASH_RD_EN)
    else $error("read enable missing");
  a_no_overlap: assert property (!(FLASH_ERASE_EN && FLASH_PROG_EN))
    else $error("erase and program together");
  a_erase_min: assert property ($rose(FLASH_ERASE_EN)
    |-> FLASH_ERASE_EN[*8])
    else $error("erase pulse too short");
  a_prog_min: assert property ($rose(FLASH_PROG_EN)
    |-> FLASH_PROG_EN[*3])
    else $error("program pulse too short");
  a_prog_end: assert property ($rose(FLASH_PROG_EN)
    |-> ##[1:300] !FLASH_PROG_EN)
    else $error("program pulse never ends");
  a_prog_hold: assert property (FLASH_PROG_EN && $past(FLASH_PROG_EN)
    |-> $stable(FLASH_WDATA) && $stable(FLASH_COL))
    else $error("data or column moved in pulse");
endmodule
`default_nettype wire

// ==== fwec_flash_model.sv ====
// Behavioural flash array that measures program and erase pulses
`timescale 1ns/1ps
`default_nettype none
module fwec_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pulses and data from the controller
  input wire logic erase_en,
  input wire logic prog_en,
  input wire logic [7:0] wdata,
  input wire logic [5:0] col,
  // Fetch request
  output logic read_req
);
  logic [2:0] cyc_r;
  logic [15:0] erun_r, prun_r, elen_r, plen_r, ecount_r, pcount_r;
  logic [7:0] pdata_r;
  logic [5:0] pcol_r;
  // Fetch every eighth cycle; length and count of each pulse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_r <= 3'h0;
      read_req <= 1'b0;
      erun_r <= 16'h0;
      prun_r <= 16'h0;
      ecount_r <= 16'h0;
      pcount_r <= 16'h0;
    end else begin
      cyc_r <= cyc_r + 3'h1;
      read_req <= (cyc_r == 3'h7);
      if (erase_en) begin
        erun_r <= erun_r + 16'h1;
      end else if (erun_r != 16'h0) begin
        elen_r <= erun_r;
        erun_r <= 16'h0;
        ecount_r <= ecount_r + 16'h1;
      end
      if (prog_en) begin
        prun_r <= prun_r + 16'h1;
        pdata_r <= wdata;
        pcol_r <= col;
      end else if (prun_r != 16'h0) begin
        plen_r <= prun_r;
        prun_r <= 16'h0;
        pcount_r <= pcount_r + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== fwec_ctrl_tb.sv ====
// Self-checking testbench for the flash write and erase controller
`timescale 1ns/1ps
`default_nettype none
`include "fwec_map.vh"
module fwec_ctrl_tb;
  localparam logic [7:0] tim = `FWEC_IDX_WRITE_TIMING;
  localparam logic [7:0] adl = `FWEC_IDX_ADDRESS_LOW;
  localparam logic [7:0] adh = `FWEC_IDX_ADDRESS_HIGH;
  localparam logic [7:0] ctl = `FWEC_IDX_OPERATION_CONTROL;
  localparam logic [7:0] dat = `FWEC_IDX_WRITE_DATA;
  logic clk = 0, rst = 1, hw = 0, rdy, resp, er, pr, rq, rde;
  logic [1:0] ht = 0;
  logic [31:0] ha = 0, hwd = 0, q, hrd, n;
  logic [7:0] wd;
  logic [5:0] col;
  logic [4:0] pg;
  logic [2:0] row;
  int errors = 0, tests_run = 0;
  always #50 clk = ~clk;
  fwec_ctrl DUT (.REF_CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(ha),
    .HTRANS(ht), .HWRITE(hw), .HSIZE(3'h2), .HWDATA(hwd), .HREADY(rdy),
    .HRDATA(hrd), .HREADYOUT(rdy), .HRESP(resp), .FLASH_READ_REQ(rq),
    .FLASH_RD_EN(rde), .FLASH_ERASE_EN(er), .FLASH_PROG_EN(pr),
    .FLASH_PAGE(pg), .FLASH_ROW(row), .FLASH_COL(col), .FLASH_WDATA(wd));
  fwec_flash_model flash (.clk(clk), .rst(rst), .erase_en(er),
    .prog_en(pr), .wdata(wd), .col(col), .read_req(rq));
  task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; read data lands in q
  task bus(input [7:0] i, input w, input [7:0] d);
    @(posedge clk);
    ha <= {22'h0, i, 2'h0};
    ht <= 2'h2;
    hw <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    ht <= 2'h0;
    hwd <= {24'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    q = hrd;
  endtask
  task poll(input int b);
    int k;
    k = 0;
    do begin
      bus(ctl, 0, 0);
      k++;
    end while (q[b] !== 1'b0 && k < 400);
    chk(q[b], 0);
  endtask
  task rdcount;
    n = 0;
    repeat (16) begin
      @(negedge clk);
      n = n + rde;
    end
  endtask
  task t_reset;
    bus(tim, 0, 0); chk(q, 32'h25);
    bus(adl, 0, 0); chk(q, 0);
    bus(adh, 0, 0); chk(q, 0);
    bus(dat, 0, 0); chk(q, 0);
    bus(ctl, 0, 0); chk(q[7:6], 0);
    bus(8'h10, 0, 0); chk(q, 0);
  endtask
  task t_addr;
    bus(tim, 1, 8'h0D);
    bus(tim, 0, 0); chk(q, 32'h0D);
    bus(adh, 1, 8'h2B);
    bus(adl, 1, 8'hC5);
    repeat (2) @(negedge clk);
    chk(pg, 5'h15);
    chk(row, 3'h7);
    chk(col, 6'h05);
  endtask
  task t_erase;
    bus(ctl, 1, 1);
    bus(ctl, 0, 0); chk(q[7], 1);
    chk(q[1:0], 0);
    bus(ctl, 1, 2);
    poll(7);
    chk(flash.elen_r, 13 * `FWEC_ERASE_UNITS + 2);
    chk(flash.pcount_r, 0);
  endtask
  task t_write;
    int i;
    bus(ctl, 1, 3);
    for (i = 0; i < 2000 && flash.ecount_r !== 2; i++) @(posedge clk);
    chk(flash.pcount_r, 0);
    for (i = 5; i < 64; i++) begin
      bus(dat, 1, i[7:0] ^ 8'hA5);
      poll(6);
      chk(flash.pdata_r, i[7:0] ^ 8'hA5);
      chk(flash.pcol_r, i);
    end
    chk(flash.plen_r, 13 * `FWEC_PROG_UNITS + 2);
    bus(ctl, 0, 0); chk(q[7], 0);
  endtask
  task t_continuous_read;
    bus(ctl, 1, 8'h10);
    repeat (2) @(negedge clk);
    rdcount; chk(n, 16);
    bus(ctl, 1, 0);
    repeat (2) @(negedge clk);
    rdcount; chk(n, 2);
  endtask
  task results;
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reset, scenarios, watchdog
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_addr;
    t_erase;
    t_write;
    t_continuous_read;
    results;
  end
  initial begin
    #2000000;
    errors++;
    results;
  end
endmodule
bind fwec_ctrl fwec_ctrl_checker chk_i (.REF_CLK(REF_CLK), .RST(RST),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .FLASH_READ_REQ(FLASH_READ_REQ), .FLASH_RD_EN(FLASH_RD_EN),
  .FLASH_ERASE_EN(FLASH_ERASE_EN), .FLASH_PROG_EN(FLASH_PROG_EN),
  .FLASH_WDATA(FLASH_WDATA), .FLASH_COL(FLASH_COL));
`default_nettype wire
